// ===== hdl/pswc_defines.vh
// Constants for the pin select and wake configuration block
// Overview of operation
// - Deep-sleep alt routes suspend pins to voltage pins
// - State-check bit enables sleep-state check in sequence
// - Multi pin select: 1xx/01x/000/001 decode
// - Mouse clock pin from alt and mouse GPIO
// - Mouse data pin from alt and mouse GPIO
// - Keyboard clock pin from alt and keyboard GPIO
// - Keyboard data pin from alt and keyboard GPIO
// - Both registers held in battery domain
// - Hysteresis-disable bit zero enables detect hysteresis
// - Wake bit gates keyboard and mouse wake
// - Key select picks wake key, extension zero
// - Key select picks wake key, extension one
// - Mouse mode: click only, or click/movement
`ifndef PSWC_DEFINES_VH
`define PSWC_DEFINES_VH
// Register indices, byte address is four times the index
`define PSWC_IDX_MFS4 8'h2C
`define PSWC_IDX_WAKE 8'h2D
`define PSWC_IDX_AUX 8'h2A
`define PSWC_IDX_UCODE 8'h2E
`define PSWC_IDX_STAT 8'h30
`define PSWC_IDX_CLR 8'h31
`define PSWC_IDX_EN 8'h32
// Reset values and writable masks
`define PSWC_MFS4_RST 8'h1C
`define PSWC_MFS4_MASK 8'hDF
`define PSWC_WAKE_RST 8'h28
`define PSWC_WAKE_MASK 8'h7F
`define PSWC_AUX_RST 8'h05
`define PSWC_AUX_MASK 8'h0F
`define PSWC_UCODE_RST 8'h29
// Field positions, first register
`define PSWC_B_DSW_ALT 7
`define PSWC_B_STATE_CHK 6
`define PSWC_B_MP_ALT 4
`define PSWC_B_MCLK_ALT 3
`define PSWC_B_MDAT_ALT 2
`define PSWC_B_KEYBOARD_CLOCK_ALT 1
`define PSWC_B_KDAT_ALT 0
// Field positions, wake register
`define PSWC_B_HYS_DIS 6
`define PSWC_B_LVL_SEL 5
`define PSWC_B_KEY_EXT 4
`define PSWC_B_WAKE_EN 3
`define PSWC_B_KEY_SEL_HI 2
`define PSWC_B_KEY_SEL_LO 1
`define PSWC_B_MOUSE_MODE 0
// Field positions, auxiliary select register
`define PSWC_B_MO_GPIO 0
`define PSWC_B_KB_GPIO 1
`define PSWC_B_MP_GPIO 2
`define PSWC_B_MP_WDOG 3
// Pin function codes
`define PSWC_FN_NATIVE 2'h0
`define PSWC_FN_GPIO 2'h1
`define PSWC_FN_ALT_A 2'h2
`define PSWC_FN_ALT_B 2'h3
// Resume-reset falling levels in millivolts
`define PSWC_MV_00 12'hB86
`define PSWC_MV_01 12'h9C4
`define PSWC_MV_10 12'hBEA
`define PSWC_MV_11 12'hAF0
// Scan codes of the keyboard wake matcher
`define PSWC_SC_BREAK 8'hF0
`define PSWC_SC_EXT 8'hE0
`define PSWC_SC_CTRL 8'h14
`define PSWC_SC_ALT 8'h11
`define PSWC_SC_ESC 8'h76
`define PSWC_SC_F1 8'h05
`define PSWC_SC_OSWAKE 8'h5E
`define PSWC_SC_OSPWR 8'h37
// Interrupt status bits
`define PSWC_ST_KBD 0
`define PSWC_ST_MOUSE 1
`endif

// ===== hdl/pswc_pin_mux.v
// Pin function decode for the shared multi-function pins
`timescale 1ns/10ps
`include "pswc_defines.vh"
module pswc_pin_mux (
  input wire [7:0] mfs4_i, // First configuration register
  input wire [7:0] aux_i, // Auxiliary select register
  output reg [1:0] multi_fn_o, // Multi-purpose pin function
  output reg [1:0] mclk_fn_o, // Mouse clock pin function
  output reg [1:0] mdat_fn_o, // Mouse data pin function
  output reg [1:0] keyboard_clock_fn_o, // Keyboard clock pin function
  output reg [1:0] kdat_fn_o // Keyboard data pin function
);
  // Pair decode: alt wins, then GPIO, else native
  function [1:0] pair_fn;
    input alt;
    input gp;
    begin
      if (alt)
        pair_fn = `PSWC_FN_ALT_A;
      else if (gp)
        pair_fn = `PSWC_FN_GPIO;
      else
        pair_fn = `PSWC_FN_NATIVE;
    end
  endfunction

  // Decode of every shared pin
  always @* begin
    // ALT_B sleep suspend, ALT_A watchdog reset, native reset connect
    if (mfs4_i[`PSWC_B_MP_ALT])
      multi_fn_o = `PSWC_FN_ALT_B;
    else if (aux_i[`PSWC_B_MP_WDOG])
      multi_fn_o = `PSWC_FN_ALT_A;
    else
      multi_fn_o = aux_i[`PSWC_B_MP_GPIO] ? `PSWC_FN_GPIO : `PSWC_FN_NATIVE;
    // ALT_B suspend warning, ALT_A infrared wake output
    if (mfs4_i[`PSWC_B_MCLK_ALT])
      mclk_fn_o = aux_i[`PSWC_B_MO_GPIO] ? `PSWC_FN_ALT_B : `PSWC_FN_ALT_A;
    else
      mclk_fn_o = aux_i[`PSWC_B_MO_GPIO] ? `PSWC_FN_GPIO : `PSWC_FN_NATIVE;
    mdat_fn_o = pair_fn(mfs4_i[`PSWC_B_MDAT_ALT], aux_i[`PSWC_B_MO_GPIO]);
    keyboard_clock_fn_o = pair_fn(mfs4_i[`PSWC_B_KEYBOARD_CLOCK_ALT], aux_i[`PSWC_B_KB_GPIO]);
    kdat_fn_o = pair_fn(mfs4_i[`PSWC_B_KDAT_ALT], aux_i[`PSWC_B_KB_GPIO]);
  end
endmodule // pswc_pin_mux

// ===== hdl/pswc_wake_match.v
// Keyboard and mouse wake event matcher
`timescale 1ns/10ps
`include "pswc_defines.vh"
module pswc_wake_match (
  input wire clk_i, // System clock
  input wire srst_i, // Synchronous reset
  input wire key_ext_i, // Key extension bit
  input wire [1:0] key_sel_i, // Key select
  input wire mouse_mode_i, // Mouse wake mode
  input wire [7:0] user_code_i, // User wake scan code
  input wire kbd_valid_i, // Scan code byte strobe
  input wire [7:0] kbd_code_i, // Scan code byte
  input wire mouse_valid_i, // Mouse packet strobe
  input wire mouse_click_i, // Any button pressed
  input wire mouse_move_i, // Nonzero movement
  output reg kbd_hit_o, // Key match, one cycle
  output reg mouse_hit_o // Mouse match, one cycle
);
  reg brk_r;
  reg ext_r;
  reg ctrl_r;
  reg alt_r;
  reg make;
  reg hit;

  // Match of the current byte against the selected wake key
  always @* begin
    make = kbd_valid_i && !brk_r && kbd_code_i != `PSWC_SC_BREAK
           && kbd_code_i != `PSWC_SC_EXT;
    hit = 1'b0;
    case ({key_ext_i, key_sel_i})
      3'b000: hit = ctrl_r && !ext_r && kbd_code_i == `PSWC_SC_ESC;
      3'b001: hit = ctrl_r && !ext_r && kbd_code_i == `PSWC_SC_F1;
      3'b010: hit = ctrl_r && !ext_r && kbd_code_i == user_code_i;
      3'b011: hit = 1'b1;
      3'b100: hit = ext_r && kbd_code_i == `PSWC_SC_OSWAKE;
      3'b101: hit = ext_r && kbd_code_i == `PSWC_SC_OSPWR;
      3'b110: hit = ctrl_r && alt_r && !ext_r && kbd_code_i == user_code_i;
      3'b111: hit = !ext_r && kbd_code_i == user_code_i;
      default: hit = 1'b0;
    endcase
  end

  // Prefix and modifier tracking, hit pulses
  always @(posedge clk_i) begin
    if (srst_i) begin
      brk_r <= 1'b0;
      ext_r <= 1'b0;
      ctrl_r <= 1'b0;
      alt_r <= 1'b0;
      kbd_hit_o <= 1'b0;
      mouse_hit_o <= 1'b0;
    end else begin
      kbd_hit_o <= make && hit;
      mouse_hit_o <= mouse_valid_i && (mouse_click_i || (mouse_mode_i && mouse_move_i));
      if (kbd_valid_i) begin
        if (kbd_code_i == `PSWC_SC_BREAK) begin
          brk_r <= 1'b1;
        end else if (kbd_code_i == `PSWC_SC_EXT) begin
          ext_r <= 1'b1;
        end else begin
          // Either-side modifier, make sets and break clears
          if (kbd_code_i == `PSWC_SC_CTRL)
            ctrl_r <= !brk_r;
          if (kbd_code_i == `PSWC_SC_ALT)
            alt_r <= !brk_r;
          brk_r <= 1'b0;
          ext_r <= 1'b0;
        end
      end
    end
  end
endmodule // pswc_wake_match

// ===== hdl/pswc_top.v
// Pin select and wake configuration registers with AHB-Lite slave
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "pswc_defines.vh"
module pswc_top (
  input wire clk_i, // 40 MHz clock
  input wire srst_i, // Synchronous reset, battery domain
  input wire hsel_i, // AHB slave select
  input wire [31:0] haddr_i, // AHB address
  input wire [1:0] htrans_i, // AHB transfer type
  input wire hwrite_i, // AHB write
  input wire [2:0] hsize_i, // AHB size
  input wire [31:0] hwdata_i, // AHB write data
  input wire hready_i, // AHB bus ready
  output reg [31:0] hrdata_o, // AHB read data
  output reg hreadyout_o, // AHB slave ready
  output reg hresp_o, // AHB response, always OKAY
  input wire kbd_valid_i, // Keyboard scan byte strobe
  input wire [7:0] kbd_code_i, // Keyboard scan byte
  input wire mouse_valid_i, // Mouse packet strobe
  input wire mouse_click_i, // Mouse button pressed
  input wire mouse_move_i, // Mouse moved
  output reg deep_sleep_alt_o, // Suspend pins on voltage pins
  output reg sleep_state_check_o, // Sequence checks sleep state
  output reg [1:0] multi_fn_o, // Multi-purpose pin function
  output reg [1:0] mclk_fn_o, // Mouse clock pin function
  output reg [1:0] mdat_fn_o, // Mouse data pin function
  output reg [1:0] keyboard_clock_fn_o, // Keyboard clock pin function
  output reg [1:0] kdat_fn_o, // Keyboard data pin function
  output reg standby_hyst_en_o, // Standby detect hysteresis on
  output reg [1:0] resume_reset_code_o, // Falling level code
  output reg [11:0] resume_reset_mv_o, // Falling level, millivolts
  output reg wake_event_o, // Wake event, one cycle
  output reg irq_o // Level interrupt
);
  reg [7:0] mfs4_r;
  reg [7:0] mfs4_nxt;
  reg [7:0] wake_r;
  reg [7:0] wake_nxt;
  reg [7:0] aux_r;
  reg [7:0] aux_nxt;
  reg [7:0] ucode_r;
  reg [7:0] ucode_nxt;
  reg [1:0] stat_r;
  reg [1:0] stat_nxt;
  reg [1:0] ien_r;
  reg [1:0] ien_nxt;
  reg wr_pend_r;
  reg [7:0] wr_idx_r;
  reg [31:0] rd_data;
  reg [11:0] lvl_mv;
  wire addr_ok;
  wire wr_go;
  wire [7:0] ap_idx;
  wire [1:0] clr_bits;
  wire kbd_hit;
  wire mouse_hit;
  wire [1:0] ev;
  wire [1:0] multi_fn;
  wire [1:0] mclk_fn;
  wire [1:0] mdat_fn;
  wire [1:0] keyboard_clock_fn;
  wire [1:0] kdat_fn;

  // Word index of an address, 8'hFF when outside the word grid
  function [7:0] word_idx;
    input [31:0] a;
    begin
      word_idx = (a[1:0] == 2'b00 && a[31:10] == 22'h00_0000) ? a[9:2] : 8'hFF;
    end
  endfunction

  // Address phase qualification
  assign addr_ok = hsel_i && htrans_i[1] && hready_i;
  assign ap_idx = word_idx(haddr_i);
  assign wr_go = wr_pend_r;
  assign clr_bits = (wr_go && wr_idx_r == `PSWC_IDX_CLR) ? hwdata_i[1:0] : 2'b00;

  // Wake gating by the enable bit
  assign ev[`PSWC_ST_KBD] = kbd_hit && wake_r[`PSWC_B_WAKE_EN];
  assign ev[`PSWC_ST_MOUSE] = mouse_hit && wake_r[`PSWC_B_WAKE_EN];

  // Next register values from the write data phase
  always @* begin
    mfs4_nxt = mfs4_r;
    wake_nxt = wake_r;
    aux_nxt = aux_r;
    ucode_nxt = ucode_r;
    ien_nxt = ien_r;
    if (wr_go) begin
      case (wr_idx_r)
        `PSWC_IDX_MFS4: mfs4_nxt = hwdata_i[7:0] & `PSWC_MFS4_MASK;
        `PSWC_IDX_WAKE: wake_nxt = hwdata_i[7:0] & `PSWC_WAKE_MASK;
        `PSWC_IDX_AUX: aux_nxt = hwdata_i[7:0] & `PSWC_AUX_MASK;
        `PSWC_IDX_UCODE: ucode_nxt = hwdata_i[7:0];
        `PSWC_IDX_EN: ien_nxt = hwdata_i[1:0];
        default: ucode_nxt = ucode_r;
      endcase
    end
    // Set wins over clear
    stat_nxt = (stat_r & ~clr_bits) | ev;
  end

  // Read mux on the forwarded values so a read right after a write sees it
  always @* begin
    rd_data = 32'h0000_0000;
    case (ap_idx)
      `PSWC_IDX_MFS4: rd_data = {24'h00_0000, mfs4_nxt};
      `PSWC_IDX_WAKE: rd_data = {24'h00_0000, wake_nxt};
      `PSWC_IDX_AUX: rd_data = {24'h00_0000, aux_nxt};
      `PSWC_IDX_UCODE: rd_data = {24'h00_0000, ucode_nxt};
      `PSWC_IDX_STAT: rd_data = {30'h0000_0000, stat_nxt};
      `PSWC_IDX_EN: rd_data = {30'h0000_0000, ien_nxt};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Falling level of the resume reset by hysteresis and level bits
  always @* begin
    case ({wake_r[`PSWC_B_HYS_DIS], wake_r[`PSWC_B_LVL_SEL]})
      2'b00: lvl_mv = `PSWC_MV_00;
      2'b01: lvl_mv = `PSWC_MV_01;
      2'b10: lvl_mv = `PSWC_MV_10;
      2'b11: lvl_mv = `PSWC_MV_11;
      default: lvl_mv = `PSWC_MV_00;
    endcase
  end

  // AHB slave and configuration registers; srst_i is the battery domain reset
  always @(posedge clk_i) begin
    if (srst_i) begin
      mfs4_r <= `PSWC_MFS4_RST;
      wake_r <= `PSWC_WAKE_RST;
      aux_r <= `PSWC_AUX_RST;
      ucode_r <= `PSWC_UCODE_RST;
      stat_r <= 2'b00;
      ien_r <= 2'b00;
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      mfs4_r <= mfs4_nxt;
      wake_r <= wake_nxt;
      aux_r <= aux_nxt;
      ucode_r <= ucode_nxt;
      stat_r <= stat_nxt;
      ien_r <= ien_nxt;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      wr_pend_r <= addr_ok && hwrite_i && hsize_i == 3'b010;
      wr_idx_r <= ap_idx;
      if (addr_ok && !hwrite_i)
        hrdata_o <= rd_data;
    end
  end

  // Registered block outputs
  always @(posedge clk_i) begin
    if (srst_i) begin
      deep_sleep_alt_o <= 1'b0;
      sleep_state_check_o <= 1'b0;
      multi_fn_o <= `PSWC_FN_NATIVE;
      mclk_fn_o <= `PSWC_FN_NATIVE;
      mdat_fn_o <= `PSWC_FN_NATIVE;
      keyboard_clock_fn_o <= `PSWC_FN_NATIVE;
      kdat_fn_o <= `PSWC_FN_NATIVE;
      standby_hyst_en_o <= 1'b1;
      resume_reset_code_o <= 2'b00;
      resume_reset_mv_o <= `PSWC_MV_00;
      wake_event_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      deep_sleep_alt_o <= mfs4_r[`PSWC_B_DSW_ALT];
      sleep_state_check_o <= mfs4_r[`PSWC_B_STATE_CHK];
      multi_fn_o <= multi_fn;
      mclk_fn_o <= mclk_fn;
      mdat_fn_o <= mdat_fn;
      keyboard_clock_fn_o <= keyboard_clock_fn;
      kdat_fn_o <= kdat_fn;
      standby_hyst_en_o <= !wake_r[`PSWC_B_HYS_DIS];
      resume_reset_code_o <= {wake_r[`PSWC_B_HYS_DIS], wake_r[`PSWC_B_LVL_SEL]};
      resume_reset_mv_o <= lvl_mv;
      wake_event_o <= |ev;
      irq_o <= |(stat_r & ien_r);
    end
  end

  // Pin function decode
  pswc_pin_mux u_pin_mux (
    .mfs4_i(mfs4_r),
    .aux_i(aux_r),
    .multi_fn_o(multi_fn),
    .mclk_fn_o(mclk_fn),
    .mdat_fn_o(mdat_fn),
    .keyboard_clock_fn_o(keyboard_clock_fn),
    .kdat_fn_o(kdat_fn)
  );

  // Keyboard and mouse matcher
  pswc_wake_match u_wake_match (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .key_ext_i(wake_r[`PSWC_B_KEY_EXT]),
    .key_sel_i(wake_r[`PSWC_B_KEY_SEL_HI:`PSWC_B_KEY_SEL_LO]),
    .mouse_mode_i(wake_r[`PSWC_B_MOUSE_MODE]),
    .user_code_i(ucode_r),
    .kbd_valid_i(kbd_valid_i),
    .kbd_code_i(kbd_code_i),
    .mouse_valid_i(mouse_valid_i),
    .mouse_click_i(mouse_click_i),
    .mouse_move_i(mouse_move_i),
    .kbd_hit_o(kbd_hit),
    .mouse_hit_o(mouse_hit)
  );
endmodule // pswc_top

// ===== sim/pswc_top_sva.sv
// Assertion checker for the pin select and wake block
`timescale 1ns/10ps
module pswc_top_sva (
  input wire clk_i, // Clock
  input wire srst_i, // Reset
  input wire hsel_i, // Select
  input wire [31:0] haddr_i, // Address
  input wire [1:0] htrans_i, // Type
  input wire hwrite_i, // Write
  input wire hready_i, // Ready
  input wire kbd_valid_i, // Key strobe
  input wire mouse_valid_i, // Mouse strobe
  input wire [31:0] hrdata_o, // Read data
  input wire hreadyout_o, // Slave ready
  input wire hresp_o, // Response
  input wire deep_sleep_alt_o, // Suspend route
  input wire sleep_state_check_o, // State check
  input wire [1:0] multi_fn_o, // Multi pin
  input wire [1:0] mclk_fn_o, // Mouse clock
  input wire [1:0] mdat_fn_o, // Mouse data
  input wire [1:0] keyboard_clock_fn_o, // Kbd clock
  input wire [1:0] kdat_fn_o, // Kbd data
  input wire standby_hyst_en_o, // Hysteresis
  input wire [1:0] resume_reset_code_o, // Level code
  input wire [11:0] resume_reset_mv_o, // Level mV
  input wire wake_event_o // Wake pulse
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Read address phases of the two registers
  wire rd_mfs = hsel_i && htrans_i[1] && hready_i && !hwrite_i && haddr_i == 32'h0000_00B0;
  wire rd_wake = hsel_i && htrans_i[1] && hready_i && !hwrite_i && haddr_i == 32'h0000_00B4;
  reg [7:0] seen_r;
  // History of key and mouse strobes
  always @(posedge clk_i) begin
    seen_r <= srst_i ? 8'h00 : {seen_r[6:0], kbd_valid_i | mouse_valid_i};
  end
  bus_okay_a: assert property (hreadyout_o && !hresp_o) else $error("bus not ready or okay");
  mfs_reserved_a: assert property (
    rd_mfs |=> hrdata_o[5] == 1'b0 && hrdata_o[31:8] == 24'h00_0000) else $error("mfs bits");
  wake_reserved_a: assert property (
    rd_wake |=> hrdata_o[31:7] == 25'h000_0000) else $error("wake reserved bits");
  suspend_route_a: assert property (
    rd_mfs |=> ##1 deep_sleep_alt_o == $past(hrdata_o[7]) &&
    sleep_state_check_o == $past(hrdata_o[6])) else $error("route bits mismatch");
  multi_pin_a: assert property (
    rd_mfs |=> ##1 (multi_fn_o == 2'h3) == $past(hrdata_o[4])) else $error("multi pin");
  alt_pins_a: assert property (
    rd_mfs |=> ##1 {mclk_fn_o[1], mdat_fn_o[1], keyboard_clock_fn_o[1], kdat_fn_o[1]} ==
    $past(hrdata_o[3:0])) else $error("alt pin function");
  no_alt_b_a: assert property (
    mdat_fn_o != 2'h3 && keyboard_clock_fn_o != 2'h3 && kdat_fn_o != 2'h3) else $error("bad code");
  level_code_a: assert property (
    rd_wake |=> ##1 resume_reset_code_o == $past(hrdata_o[6:5])) else $error("level code");
  level_mv_a: assert property (
    resume_reset_mv_o == (resume_reset_code_o == 2'h0 ? 12'hB86 :
    resume_reset_code_o == 2'h1 ? 12'h9C4 : resume_reset_code_o == 2'h2 ? 12'hBEA : 12'hAF0))
    else $error("level millivolts");
  hyst_a: assert property (
    standby_hyst_en_o == !resume_reset_code_o[1]) else $error("hysteresis enable");
  wake_cause_a: assert property (
    wake_event_o |-> seen_r != 8'h00) else $error("wake without strobe");
  cover property (rd_mfs);
  cover property (rd_wake);
  cover property (wake_event_o);
endmodule // pswc_top_sva
bind pswc_top pswc_top_sva i_sva (.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .kbd_valid_i(kbd_valid_i), .mouse_valid_i(mouse_valid_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .deep_sleep_alt_o(deep_sleep_alt_o),
  .sleep_state_check_o(sleep_state_check_o), .multi_fn_o(multi_fn_o), .mclk_fn_o(mclk_fn_o),
  .mdat_fn_o(mdat_fn_o), .keyboard_clock_fn_o(keyboard_clock_fn_o), .kdat_fn_o(kdat_fn_o),
  .standby_hyst_en_o(standby_hyst_en_o), .resume_reset_code_o(resume_reset_code_o),
  .resume_reset_mv_o(resume_reset_mv_o), .wake_event_o(wake_event_o));

// ===== sim/testbench.sv
// Self-checking testbench for the pin select and wake block
`timescale 1ns/10ps
module testbench;
  reg clk_i, srst_i, hsel_i, hwrite_i, kbd_valid_i, mouse_valid_i, mouse_click_i, mouse_move_i;
  reg [31:0] haddr_i, hwdata_i, rdat;
  reg [1:0] htrans_i;
  reg [2:0] hsize_i;
  reg [7:0] kbd_code_i;
  reg [23:0] s;
  wire [31:0] hrdata_o;
  wire hreadyout_o, hresp_o, deep_sleep_alt_o, sleep_state_check_o, standby_hyst_en_o;
  wire wake_event_o, irq_o;
  wire [1:0] multi_fn_o, mclk_fn_o, mdat_fn_o, keyboard_clock_fn_o, kdat_fn_o, resume_reset_code_o;
  wire [11:0] resume_reset_mv_o;
  integer failures, comparisons, wakes, n, i, k;
  pswc_top i_dut (.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .kbd_valid_i(kbd_valid_i), .kbd_code_i(kbd_code_i), .mouse_valid_i(mouse_valid_i),
    .mouse_click_i(mouse_click_i), .mouse_move_i(mouse_move_i),
    .deep_sleep_alt_o(deep_sleep_alt_o), .sleep_state_check_o(sleep_state_check_o),
    .multi_fn_o(multi_fn_o), .mclk_fn_o(mclk_fn_o), .mdat_fn_o(mdat_fn_o),
    .keyboard_clock_fn_o(keyboard_clock_fn_o), .kdat_fn_o(kdat_fn_o), .standby_hyst_en_o(standby_hyst_en_o),
    .resume_reset_code_o(resume_reset_code_o), .resume_reset_mv_o(resume_reset_mv_o),
    .wake_event_o(wake_event_o), .irq_o(irq_o));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Count wake pulses
  always @(posedge clk_i) begin
    if (wake_event_o === 1'b1) wakes <= wakes + 1;
  end
  task finish_test;
    begin
      if (failures == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task xfer(input w, input [31:0] a, input [31:0] d);
    begin
      hsel_i <= 1'b1; haddr_i <= a; hwrite_i <= w; htrans_i <= 2'h2;
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1) @(posedge clk_i);
      htrans_i <= 2'h0; hwdata_i <= d;
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1) @(posedge clk_i);
      rdat = hrdata_o;
    end
  endtask
  task rd(input [31:0] a, input [31:0] exp);
    begin
      xfer(1'b0, a, 32'h0000_0000);
      chk(rdat, exp);
    end
  endtask
  task key(input [7:0] b);
    begin
      kbd_valid_i <= 1'b1; kbd_code_i <= b;
      @(posedge clk_i);
      kbd_valid_i <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask
  task mouse(input c, input m);
    begin
      mouse_valid_i <= 1'b1; mouse_click_i <= c; mouse_move_i <= m;
      @(posedge clk_i);
      mouse_valid_i <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
  endtask
  function [23:0] seq(input [2:0] m);
    case (m)
      3'h0: seq = 24'h00_1476;
      3'h1: seq = 24'h00_1405;
      3'h2: seq = 24'h00_1429;
      3'h3: seq = 24'h00_001C;
      3'h4: seq = 24'h00_E05E;
      3'h5: seq = 24'h00_E037;
      3'h6: seq = 24'h14_1129;
      default: seq = 24'h00_0029;
    endcase
  endfunction
  task t_reset;
    begin
      repeat (2) @(posedge clk_i);
      chk({multi_fn_o, mclk_fn_o, mdat_fn_o, keyboard_clock_fn_o, kdat_fn_o}, 10'h3E0);
      chk({standby_hyst_en_o, resume_reset_code_o, resume_reset_mv_o}, 15'h59C4);
      rd(32'h0000_00B0, 32'h0000_001C);
      rd(32'h0000_00B4, 32'h0000_0028);
      rd(32'h0000_0100, 32'h0000_0000);
    end
  endtask
  task t_reserved;
    begin
      xfer(1'b1, 32'h0000_00B0, 32'hFFFF_FFFF);
      rd(32'h0000_00B0, 32'h0000_00DF);
      repeat (2) @(posedge clk_i);
      chk({deep_sleep_alt_o, sleep_state_check_o}, 2'h3);
      // Byte-sized write is refused, unaligned read gives zero
      hsize_i <= 3'h0;
      xfer(1'b1, 32'h0000_00B0, 32'h0000_0000);
      hsize_i <= 3'h2;
      rd(32'h0000_00B0, 32'h0000_00DF);
      rd(32'h0000_00B1, 32'h0000_0000);
      xfer(1'b1, 32'h0000_00B4, 32'hFFFF_FFFF);
      rd(32'h0000_00B4, 32'h0000_007F);
    end
  endtask
  task t_mux;
    for (i = 0; i < 512; i = i + 1) begin
      xfer(1'b1, 32'h0000_00B0, {27'h0, i[4:0]});
      xfer(1'b1, 32'h0000_00A8, {28'h0, i[8:5]});
      repeat (3) @(posedge clk_i);
      chk({multi_fn_o, mclk_fn_o, mdat_fn_o, keyboard_clock_fn_o, kdat_fn_o},
        {i[4] ? 2'h3 : i[8] ? 2'h2 : {1'b0, i[7]}, i[3], i[5], i[2] ? 2'h2 : {1'b0, i[5]},
        i[1] ? 2'h2 : {1'b0, i[6]}, i[0] ? 2'h2 : {1'b0, i[6]}});
    end
  endtask
  task t_level;
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b1, 32'h0000_00B4, {25'h0, i[1:0], 5'h08});
      repeat (3) @(posedge clk_i);
      chk({standby_hyst_en_o, resume_reset_code_o}, {!i[1], i[1:0]});
      chk(resume_reset_mv_o,
        i == 0 ? 12'hB86 : i == 1 ? 12'h9C4 : i == 2 ? 12'hBEA : 12'hAF0);
    end
  endtask
  task t_keys;
    begin
      xfer(1'b1, 32'h0000_00C8, 32'h0000_0003);
      for (i = 0; i < 8; i = i + 1) begin
        xfer(1'b1, 32'h0000_00B4, {27'h0, i[2], 1'b1, i[1:0], 1'b0});
        n = wakes;
        s = seq(i[2:0]);
        for (k = 2; k >= 0; k = k - 1) if (s[k*8 +: 8] != 8'h00) key(s[k*8 +: 8]);
        if (s[15:8] == 8'h14 || i == 6) begin
          key(8'hF0); key(8'h14); key(8'hF0); key(8'h11);
        end
        repeat (6) @(posedge clk_i);
        chk(wakes - n, 1);
        chk(irq_o, 1'b1);
        rd(32'h0000_00C0, 32'h0000_0001);
        xfer(1'b1, 32'h0000_00C4, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 1'b0);
      end
      xfer(1'b1, 32'h0000_00B4, 32'h0000_0008);
      n = wakes;
      key(8'h76);
      xfer(1'b1, 32'h0000_00B4, 32'h0000_0006);
      key(8'h1C);
      repeat (6) @(posedge clk_i);
      chk(wakes - n, 0);
    end
  endtask
  task t_mouse;
    begin
      xfer(1'b1, 32'h0000_00C8, 32'h0000_0000);
      xfer(1'b1, 32'h0000_00B4, 32'h0000_0008);
      n = wakes;
      mouse(1'b0, 1'b1);
      chk(wakes - n, 0);
      mouse(1'b1, 1'b0);
      chk(wakes - n, 1);
      chk(irq_o, 1'b0);
      rd(32'h0000_00C0, 32'h0000_0002);
      xfer(1'b1, 32'h0000_00C8, 32'h0000_0002);
      repeat (3) @(posedge clk_i);
      chk(irq_o, 1'b1);
      xfer(1'b1, 32'h0000_00C4, 32'h0000_0002);
      xfer(1'b1, 32'h0000_00B4, 32'h0000_0009);
      mouse(1'b0, 1'b1);
      chk(wakes - n, 2);
      xfer(1'b1, 32'h0000_00B4, 32'h0000_0001);
      mouse(1'b1, 1'b1);
      chk(wakes - n, 2);
      rd(32'h0000_00C0, 32'h0000_0002);
      // Status ignores writes, clear register reads zero
      xfer(1'b1, 32'h0000_00C0, 32'h0000_0000);
      rd(32'h0000_00C0, 32'h0000_0002);
      rd(32'h0000_00C4, 32'h0000_0000);
    end
  endtask
  // Main sequence
  initial begin
    failures = 0; comparisons = 0; wakes = 0;
    srst_i = 1'b1; hsel_i = 1'b0; hwrite_i = 1'b0; htrans_i = 2'h0; hsize_i = 3'h2;
    haddr_i = 32'h0; hwdata_i = 32'h0; kbd_valid_i = 1'b0; kbd_code_i = 8'h00;
    mouse_valid_i = 1'b0; mouse_click_i = 1'b0; mouse_move_i = 1'b0;
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset; t_reserved; t_mux; t_level; t_keys; t_mouse;
    finish_test;
  end
  // Watchdog
  initial begin
    #1000000;
    failures = failures + 1;
    finish_test;
  end
endmodule // testbench
